// File: dv/block_read_sequencer_asserts.sv
// Checker for the block read sequencer, on its ports only.
// Assumes one clock domain; attached by bind.
`timescale 1ns/1ps
module block_read_sequencer_asserts #(
  parameter ADDR_WIDTH = 32,
  parameter ADDR_STEP  = 8
) (
  input wire                  clk_sys,
  input wire                  rst_b,
  input wire                  ce,
  input wire                  cmd_valid,
  input wire                  cmd_ready,
  input wire                  cmd_use_accu,
  input wire [7:0]            cmd_opcode,
  input wire [31:0]           cmd_limit,
  input wire [31:0]           done_count,
  input wire                  cmd_reject,
  input wire                  bus_req,
  input wire                  bus_ack,
  input wire                  bus_berr,
  input wire                  busy,
  input wire                  done,
  input wire                  done_berr,
  input wire [ADDR_WIDTH-1:0] bus_addr
);
  // ========
  // Command capture
  wire                  take = cmd_valid && cmd_ready;
  wire                  ok   = (cmd_opcode & 8'hde) == 8'h12;
  wire                  go   = take && ok && !cmd_use_accu;
  reg  [7:0]            op_reg;
  reg  [31:0]           lim_reg;
  reg                   ua_reg, fst_reg;
  reg  [ADDR_WIDTH-1:0] la_reg;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {op_reg, lim_reg, ua_reg, fst_reg, la_reg} <= '0;
    end else if (take) begin
      {op_reg, lim_reg, ua_reg, fst_reg} <= {cmd_opcode, cmd_limit, cmd_use_accu, 1'b1};
    end else if (ce && bus_req && bus_ack && !bus_berr) begin
      {la_reg, fst_reg} <= {bus_addr, 1'b0};
    end
  end
  // ========
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_berr; ce && bus_req && bus_berr; endsequence
  sequence s_zero; go && cmd_limit == '0; endsequence
  a_addr_step: assert property (
    $rose(bus_req) && !fst_reg |-> bus_addr == la_reg + (op_reg[5] ? ADDR_STEP : 0)) else $error("address step");
  a_reject_op: assert property (
    take && !ok |=> cmd_reject && !bus_req) else $error("bad opcode taken");
  a_first_req: assert property (
    go && cmd_limit != '0 |=> bus_req && !cmd_reject) else $error("no first request");
  a_berr_stop: assert property (
    s_berr |=> !bus_req throughout (##[0:5] (done && done_berr))) else $error("bus error end");
  a_limit_zero: assert property (
    s_zero |-> ##2 (done && done_count == '0)) else $error("zero limit end");
  a_count_limit: assert property (
    done && !done_berr && !ua_reg |-> done_count == lim_reg) else $error("beat count");
  a_req_hold: assert property (
    bus_req && !bus_ack && !bus_berr |=> bus_req && $stable(bus_addr)) else $error("request dropped");
  a_ready_idle: assert property (
    cmd_ready == (ce && !busy)) else $error("ready while busy");
endmodule

// File: dv/bus_slave_model.sv
// Bus slave model: answers beats on falling edges after lat waits.
// Assumes the sequencer's default 32-bit address.
`timescale 1ns/1ps
module bus_slave_model (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire        bus_req,
  input  wire [31:0] bus_addr,
  input  wire [31:0] berr_addr,
  input  wire [1:0]  lat,
  output reg         bus_ack,
  output reg         bus_berr,
  output reg  [63:0] bus_data
);
  reg  [1:0] wait_reg;
  wire       ask = bus_req && !bus_ack && !bus_berr;
  // Data flips each idle cycle, so a stale beat looks valid again on every second idle cycle
  always @(negedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {bus_ack, bus_berr, wait_reg, bus_data} <= '0;
    end else if (ask && wait_reg == lat) begin
      {bus_ack, bus_berr} <= {bus_addr != berr_addr, bus_addr == berr_addr};
      {bus_data, wait_reg} <= {bus_addr, ~bus_addr, 2'h0};
    end else begin
      {bus_ack, bus_berr, bus_data} <= {2'h0, ~bus_data};
      wait_reg <= wait_reg + {1'b0, ask};
    end
  end
endmodule

// File: dv/test_block_read_sequencer.sv
// Self-checking bench for the block read sequencer.
// Assumes default parameters: 8-byte address step.
`timescale 1ns/1ps
module test_block_read_sequencer;
  reg         clk_sys = 0, rst_b = 0, ce = 1, cmd_valid = 0, cmd_use_accu = 0, out_ready = 1, stall = 0;
  reg  [7:0]  cmd_opcode = 8'h00;
  reg  [31:0] cmd_address = '0, cmd_limit = '0, accu_value = '0, accu_mask = '0, berr_addr = '1;
  reg  [4:0]  accu_shift = 5'h00;
  reg  [1:0]  lat = 2'h0;
  wire        cmd_ready, cmd_reject, bus_req, bus_ack, bus_berr, out_valid, busy, done, done_berr;
  wire [31:0] bus_addr, done_count;
  wire [63:0] bus_data, out_data;
  integer     err_total = 0, compares = 0;
  block_read_sequencer dut_u (.*);
  bus_slave_model slave_u (.*);
  always #12.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) out_ready <= !stall || !out_ready;
  // ========
  // Shared tasks
  task chk(input [63:0] seen, input [63:0] want);
    begin
      compares = compares + 1;
      if (seen !== want) begin
        err_total = err_total + 1;
        $display("BAD %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task results;
    begin
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task run(input [7:0] op, input [31:0] a, n, input u, input [31:0] en, input eb);
    integer     i, k, nd;
    reg  [31:0] x;
    reg  [63:0] d;
    begin
      i = 0;
      nd = 0;
      @(negedge clk_sys);
      {cmd_valid, cmd_opcode, cmd_address, cmd_limit, cmd_use_accu} = {1'b1, op, a, n, u};
      @(negedge clk_sys);
      cmd_valid = 0;
      for (k = 0; k < 300 && (k < 4 || busy !== 0 || out_valid !== 0); k = k + 1) begin
        // Look just after the falling edge, where the next rising edge's values stand
        @(negedge clk_sys);
        #1;
        if (out_valid === 1 && out_ready && ce) begin
          x = a + i * (op[5] ? 8 : 0);
          d = {x, ~x};
          chk(out_data, op[0] ? {d[31:0], d[63:32]} : d);
          i = i + 1;
        end
        if (done === 1) begin
          chk({done_berr, done_count}, {eb, en});
          nd = nd + 1;
        end
      end
      chk(i, en);
      chk(nd, 1);
    end
  endtask
  // ========
  // Scenarios
  task t_ops;
    integer j;
    for (j = 0; j < 4; j = j + 1) begin
      lat = j[1:0];
      run(8'h12 + {j[1], 4'h0, j[0]}, 32'h0000_1000, 3, 0, 3, 0);
    end
    $display("t_ops over");
  endtask
  task t_berr;
    berr_addr = 32'h0000_2010;
    run(8'h32, 32'h0000_2000, 5, 0, 2, 1);
    berr_addr = 32'h0000_3000;
    run(8'h13, 32'h0000_3000, 4, 0, 0, 1);
    berr_addr = '1;
    $display("t_berr over");
  endtask
  task t_edge;
    run(8'h13, 32'h0000_0040, 0, 0, 0, 0);
    @(negedge clk_sys);
    {cmd_valid, cmd_opcode} = {1'b1, 8'h22};
    @(negedge clk_sys);
    cmd_valid = 0;
    chk({cmd_reject, bus_req}, 2'b10);
    $display("t_edge over");
  endtask
  task t_accu;
    stall = 1;
    {accu_value, accu_mask, accu_shift} = {32'h0000_00f3, 32'h0000_000f, 5'h01};
    run(8'h32, 32'h0000_0500, 0, 1, 6, 0);
    {accu_value, accu_mask, accu_shift} = {32'h8000_0001, 32'h8000_0000, 5'h02};
    run(8'h12, 32'h0000_0600, 9, 1, 2, 0);
    stall = 0;
    $display("t_accu over");
  endtask
  // Clock enable drops while the first request waits; nothing may move
  task t_freeze;
    begin
      fork
        run(8'h33, 32'h0000_4000, 32'h0000_0004, 1'b0, 32'h0000_0004, 1'b0);
        begin
          repeat (3) @(negedge clk_sys);
          ce = 1'b0;
          repeat (4) begin
            @(negedge clk_sys);
            chk({busy, bus_req, cmd_ready, out_valid, bus_addr}, {4'b1100, 32'h0000_4000});
          end
          ce = 1'b1;
        end
      join
      $display("t_freeze over");
    end
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_b = 1;
    t_ops;
    t_berr;
    t_edge;
    t_accu;
    t_freeze;
    results;
  end
  // Runs need a few hundred cycles; 20000 leaves ample slack
  initial begin
    #(20000 * 25);
    err_total = err_total + 1;
    results;
  end
endmodule
bind block_read_sequencer block_read_sequencer_asserts #(.ADDR_WIDTH(ADDR_WIDTH), .ADDR_STEP(ADDR_STEP)) chk_u (.*);

// File: src/beat_swap_stage.v
// One-entry output register for read beats, with optional word swap.
// Assumes the consumer and producer run on clk_sys.
`timescale 1ns/1ps
`include "blk_read_regs.vh"

module beat_swap_stage #(
  parameter BEAT_WIDTH = 64
) (
  input  wire                  clk_sys,
  input  wire                  rst_b,
  input  wire                  ce,
  input  wire                  in_valid,
  output wire                  in_ready,
  input  wire [BEAT_WIDTH-1:0] in_data,
  input  wire                  in_swap,
  output wire                  out_valid,
  input  wire                  out_ready,
  output wire [BEAT_WIDTH-1:0] out_data
);

  localparam HALF = BEAT_WIDTH / 2;

  reg                  valid_reg;
  reg [BEAT_WIDTH-1:0] data_reg;
  wire                 take;

  // A new beat may enter in the same cycle the old one leaves
  assign in_ready  = ce & (~valid_reg | out_ready);
  assign take      = in_valid & in_ready;
  assign out_valid = valid_reg;
  assign out_data  = data_reg;

  // =====================================================================
  // Storage
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      valid_reg <= 1'b0;
      data_reg  <= `RST_BEAT;
    end else if (ce) begin
      if (take) begin
        valid_reg <= 1'b1;
        if (in_swap) begin
          data_reg <= {in_data[HALF-1:0], in_data[BEAT_WIDTH-1:HALF]};
        end else begin
          data_reg <= in_data;
        end
      end else if (out_ready) begin
        valid_reg <= 1'b0;
      end
    end
  end

endmodule

// File: src/blk_read_regs.vh
// Constants for the stack block read sequencer: opcodes, opcode fields,
// and reset values.
// Assumes it is included by bare name into each design file that needs it.
`ifndef BLK_READ_REGS_VH
`define BLK_READ_REGS_VH

// =====================================================================
// Stack opcodes
`define OP_FIXED_ADDRESS_BLOCK_READ   8'h12
`define OP_FIXED_ADDRESS_SWAPPED_READ 8'h13
`define OP_INCREMENTING_BLOCK_READ    8'h32
`define OP_INCREMENTING_SWAPPED_READ  8'h33

// =====================================================================
// Opcode fields
`define OP_SWAP_BIT 0
`define OP_INCR_BIT 5

// =====================================================================
// Reset values
`define RST_ADDR  32'h0000_0000
`define RST_COUNT 32'h0000_0000
`define RST_BEAT  64'h0000_0000_0000_0000

`endif

// File: src/block_read_sequencer.v
// Block read engine of a bus controller command stack: turns one stack
// opcode into a run of bus block read beats and streams the data out.
// Assumes the command source, the bus master port and the data consumer
// are all logic on clk_sys, so no input is synchronised here.
`timescale 1ns/1ps
`include "blk_read_regs.vh"

// Notes on behaviour
// - FIFO reads hold address, memory reads advance.
// - 0x12 fixed read, 0x13 swapped fixed.
// - 0x32 incrementing read, 0x33 swapped incrementing.
// - Stop on bus error or transfer limit.
// - Accumulator count: mask, rotate left, use.
module block_read_sequencer #(
  parameter ADDR_WIDTH = 32,
  parameter BEAT_WIDTH = 64,
  parameter ADDR_STEP  = 8
) (
  input  wire                  clk_sys,
  input  wire                  rst_b,
  input  wire                  ce,
  // Command from the stack
  input  wire                  cmd_valid,
  output wire                  cmd_ready,
  input  wire [7:0]            cmd_opcode,
  input  wire [ADDR_WIDTH-1:0] cmd_address,
  input  wire [31:0]           cmd_limit,
  input  wire                  cmd_use_accu,
  input  wire [31:0]           accu_value,
  input  wire [31:0]           accu_mask,
  input  wire [4:0]            accu_shift,
  output reg                   cmd_reject,
  // Bus master side
  output reg                   bus_req,
  output reg  [ADDR_WIDTH-1:0] bus_addr,
  input  wire                  bus_ack,
  input  wire                  bus_berr,
  input  wire [BEAT_WIDTH-1:0] bus_data,
  // Output data stream
  output wire                  out_valid,
  input  wire                  out_ready,
  output wire [BEAT_WIDTH-1:0] out_data,
  // Status
  output wire                  busy,
  output reg                   done,
  output reg                   done_berr,
  output reg  [31:0]           done_count
);

  // =====================================================================
  // States
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_REQ  = 4'b0010;
  localparam [3:0] ST_PUSH = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg [3:0]            state_reg;
  reg [3:0]            state_next;
  reg [ADDR_WIDTH-1:0] addr_reg;
  reg [31:0]           limit_reg;
  reg [31:0]           count_reg;
  reg                  incr_reg;
  reg                  swap_reg;
  reg                  berr_reg;
  reg [BEAT_WIDTH-1:0] beat_reg;
  reg [ADDR_WIDTH-1:0] req_addr_next;

  wire        known_op;
  wire [31:0] masked;
  wire [63:0] doubled;
  wire [31:0] accu_count;
  wire [31:0] start_limit;
  wire        cmd_take;
  wire        stage_ready;
  wire        push_done;
  wire        last_beat;

  // =====================================================================
  // Command decode
  assign known_op = (cmd_opcode == `OP_FIXED_ADDRESS_BLOCK_READ)   |
                    (cmd_opcode == `OP_FIXED_ADDRESS_SWAPPED_READ) |
                    (cmd_opcode == `OP_INCREMENTING_BLOCK_READ)    |
                    (cmd_opcode == `OP_INCREMENTING_SWAPPED_READ);

  // Rotate by doubling the word, so any shift of 0..31 is one barrel stage
  assign masked      = accu_value & accu_mask;
  assign doubled     = {masked, masked} << accu_shift;
  assign accu_count  = doubled[63:32];
  // The qualifier reaching us already chose the opcode; we only take the count
  assign start_limit = cmd_use_accu ? accu_count : cmd_limit;

  assign cmd_ready   = ce & state_reg[0];
  assign cmd_take    = cmd_valid & cmd_ready;
  assign busy        = ~state_reg[0];
  assign push_done   = state_reg[2] & stage_ready;
  assign last_beat   = (count_reg + 32'h0000_0001) >= limit_reg;

  // =====================================================================
  // Next request address; the step is applied once per accepted beat
  always @* begin
    if (state_reg[0]) begin
      req_addr_next = cmd_address;
    end else if (push_done && incr_reg) begin
      req_addr_next = addr_reg + ADDR_STEP[ADDR_WIDTH-1:0];
    end else begin
      req_addr_next = addr_reg;
    end
  end

  // =====================================================================
  // Sequencing
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_take && known_op) begin
          if (start_limit == `RST_COUNT) begin
            state_next = ST_DONE;
          end else begin
            state_next = ST_REQ;
          end
        end
      end
      ST_REQ: begin
        if (bus_berr) begin
          state_next = ST_DONE;
        end else if (bus_ack) begin
          state_next = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (stage_ready) begin
          if (last_beat) begin
            state_next = ST_DONE;
          end else begin
            state_next = ST_REQ;
          end
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= ST_IDLE;
      addr_reg   <= `RST_ADDR;
      limit_reg  <= `RST_COUNT;
      count_reg  <= `RST_COUNT;
      incr_reg   <= 1'b0;
      swap_reg   <= 1'b0;
      berr_reg   <= 1'b0;
      beat_reg   <= `RST_BEAT;
      bus_req    <= 1'b0;
      bus_addr   <= `RST_ADDR;
      cmd_reject <= 1'b0;
      done       <= 1'b0;
      done_berr  <= 1'b0;
      done_count <= `RST_COUNT;
    end else if (ce) begin
      // Low clock enable freezes all of this, the bus request included
      state_reg  <= state_next;
      cmd_reject <= cmd_take & ~known_op;
      done       <= 1'b0;
      done_berr  <= 1'b0;
      if (cmd_take && known_op) begin
        addr_reg  <= cmd_address;
        limit_reg <= start_limit;
        count_reg <= `RST_COUNT;
        incr_reg  <= cmd_opcode[`OP_INCR_BIT];
        swap_reg  <= cmd_opcode[`OP_SWAP_BIT];
        berr_reg  <= 1'b0;
      end
      if (state_reg[1] && bus_ack && !bus_berr) begin
        beat_reg <= bus_data;
      end
      if (state_reg[1] && bus_berr) begin
        berr_reg <= 1'b1;
      end
      if (push_done) begin
        count_reg <= count_reg + 32'h0000_0001;
        if (incr_reg) begin
          addr_reg <= addr_reg + ADDR_STEP[ADDR_WIDTH-1:0];
        end
      end
      // Request is dropped on the answering edge; address is held meanwhile
      bus_req  <= (state_next == ST_REQ);
      if (state_next == ST_REQ) begin
        bus_addr <= req_addr_next;
      end
      if (state_reg[3]) begin
        done       <= 1'b1;
        done_berr  <= berr_reg;
        done_count <= count_reg;
      end
    end
  end

  // =====================================================================
  // Output stage; its ready stalls the engine in ST_PUSH
  beat_swap_stage #(
    .BEAT_WIDTH (BEAT_WIDTH)
  ) u_stage (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (state_reg[2]),
    .in_ready  (stage_ready),
    .in_data   (beat_reg),
    .in_swap   (swap_reg),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

endmodule
